// File: hw/mpc_pkg.sv
package mpc_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned ON_PULSE_MS = 200;
    localparam int unsigned OFF_PULSE_MS = 4000;
    localparam int unsigned RESTART_PULSE_MS = 400;
    localparam int unsigned ON_PULSE_CYC = ON_PULSE_MS * (CLK_HZ / 1000);
    localparam int unsigned OFF_PULSE_CYC = OFF_PULSE_MS * (CLK_HZ / 1000);
    localparam int unsigned RESTART_PULSE_CYC = RESTART_PULSE_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W = 32;
    localparam int unsigned DETACH_WAIT_CYC = 16;
    localparam int unsigned RESET_HOLD_CYC = 16;

    typedef enum logic [4:0] {
        MPC_OFF = 5'h01,
        MPC_ON = 5'h02,
        MPC_DETACH = 5'h04,
        MPC_RESTART = 5'h08,
        MPC_PSM = 5'h10
    } mpc_state_t;

    // control lines as seen at the device pads, active low
    typedef struct packed {
        logic pwr_toggle_n;
        logic restart_n;
        logic wake_n;
    } mpc_pins_t;

    // outward status of the sequencer
    typedef struct packed {
        logic powered;
        logic detach_req;
        logic sys_reset;
        logic psm;
    } mpc_stat_t;
endpackage

// File: hw/mpc_low_timer.sv
`timescale 1ns/100ps
module mpc_low_timer import mpc_pkg::*; #(
    parameter int unsigned W = CNT_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic line_n,
    input wire logic [W-1:0] limit,
    output logic released_long
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic long_seen;
        logic prev_low;
        logic rel;
    } mpc_lt_t;

    mpc_lt_t s_q;
    mpc_lt_t s_d;

    // pulses one cycle on release after a low of at least limit cycles
    always_comb begin
        s_d = s_q;
        s_d.prev_low = !line_n;
        s_d.rel = 1'b0;
        if (!line_n) begin
            if (s_q.cnt < limit) begin
                s_d.cnt = s_q.cnt + {{(W-1){1'b0}}, 1'b1};
            end
            if (s_q.cnt + {{(W-1){1'b0}}, 1'b1} >= limit) begin
                s_d.long_seen = 1'b1;
            end
        end else begin
            s_d.cnt = '0;
            s_d.long_seen = 1'b0;
            s_d.rel = s_q.prev_low && s_q.long_seen;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign released_long = s_q.rel;
endmodule

// File: hw/mpc_seq.sv
`timescale 1ns/100ps
module mpc_seq import mpc_pkg::*; #(
    parameter int unsigned ON_CYC = ON_PULSE_CYC,
    parameter int unsigned OFF_CYC = OFF_PULSE_CYC,
    parameter int unsigned RESTART_CYC = RESTART_PULSE_CYC,
    parameter int unsigned DETACH_CYC = DETACH_WAIT_CYC,
    parameter int unsigned RESET_CYC = RESET_HOLD_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire mpc_pins_t pins,
    input wire logic psm_enter,
    input wire logic detach_ack,
    output mpc_stat_t stat
);
    ////////////////////////////////////////////////////////////////
    localparam logic [CNT_W-1:0] ON_LIM = CNT_W'(ON_CYC);
    localparam logic [CNT_W-1:0] OFF_LIM = CNT_W'(OFF_CYC);
    localparam logic [CNT_W-1:0] RST_LIM = CNT_W'(RESTART_CYC);
    localparam logic [15:0] DET_LIM = 16'(DETACH_CYC);
    localparam logic [15:0] RES_LIM = 16'(RESET_CYC);

    logic on_rel;
    logic off_rel;
    logic rst_rel;

    // internal pull-ups live outside, the line is sampled as given
    mpc_low_timer #(.W(CNT_W)) u_on (
        .ref_clk(ref_clk),
        .rst(rst),
        .line_n(pins.pwr_toggle_n),
        .limit(ON_LIM),
        .released_long(on_rel)
    );
    mpc_low_timer #(.W(CNT_W)) u_off (
        .ref_clk(ref_clk),
        .rst(rst),
        .line_n(pins.pwr_toggle_n),
        .limit(OFF_LIM),
        .released_long(off_rel)
    );
    mpc_low_timer #(.W(CNT_W)) u_rst (
        .ref_clk(ref_clk),
        .rst(rst),
        .line_n(pins.restart_n),
        .limit(RST_LIM),
        .released_long(rst_rel)
    );

    ////////////////////////////////////////////////////////////////
    typedef struct packed {
        mpc_state_t st;
        logic [15:0] tmr;
        mpc_stat_t out;
    } mpc_seq_t;

    mpc_seq_t s_q;
    mpc_seq_t s_d;

    always_comb begin
        s_d = s_q;
        case (s_q.st)
            MPC_OFF: begin
                if (on_rel) begin
                    s_d.st = MPC_ON;
                end
            end
            MPC_ON: begin
                if (off_rel) begin
                    s_d.st = MPC_DETACH;
                    s_d.tmr = '0;
                end else if (psm_enter) begin
                    s_d.st = MPC_PSM;
                end
            end
            MPC_PSM: begin
                if (off_rel) begin
                    s_d.st = MPC_DETACH;
                    s_d.tmr = '0;
                end else if (!pins.wake_n) begin
                    s_d.st = MPC_ON;
                end
            end
            MPC_DETACH: begin
                // detach first, power drops on ack or timeout
                s_d.tmr = s_q.tmr + 16'h0001;
                if (detach_ack || s_q.tmr + 16'h0001 >= DET_LIM) begin
                    s_d.st = MPC_OFF;
                end
            end
            MPC_RESTART: begin
                s_d.tmr = s_q.tmr + 16'h0001;
                if (s_q.tmr + 16'h0001 >= RES_LIM) begin
                    s_d.st = MPC_ON;
                end
            end
            default: begin
                s_d.st = MPC_OFF;
            end
        endcase
        // restart overrides all powered states, no detach
        if (rst_rel && s_q.st != MPC_OFF) begin
            s_d.st = MPC_RESTART;
            s_d.tmr = '0;
        end
        s_d.out.powered = s_d.st != MPC_OFF;
        s_d.out.detach_req = s_d.st == MPC_DETACH;
        s_d.out.sys_reset = s_d.st == MPC_RESTART;
        s_d.out.psm = s_d.st == MPC_PSM;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q.st <= MPC_OFF;
            s_q.tmr <= 16'h0000;
            s_q.out <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign stat = s_q.out;

    ////////////////////////////////////////////////////////////////
    property p_on;
        @(posedge ref_clk) disable iff (rst)
        (s_q.st == MPC_OFF && on_rel && !rst_rel) |=> stat.powered && !stat.detach_req;
    endproperty
    a_on: assert property (p_on) else $error("no power up after on pulse");

    property p_off;
        @(posedge ref_clk) disable iff (rst)
        (s_q.st == MPC_ON && off_rel && !rst_rel) |=> stat.detach_req && stat.powered;
    endproperty
    a_off: assert property (p_off) else $error("no shutdown after off pulse");

    property p_detach_first;
        @(posedge ref_clk) disable iff (rst)
        $fell(stat.powered) |-> $past(stat.detach_req);
    endproperty
    a_detach_first: assert property (p_detach_first) else $error("power down without detach");

    sequence s_restart_start;
        rst_rel && s_q.st != MPC_OFF;
    endsequence
    property p_restart;
        @(posedge ref_clk) disable iff (rst)
        s_restart_start |=> stat.sys_reset && !stat.detach_req;
    endproperty
    a_restart: assert property (p_restart) else $error("no system reset after restart pulse");

    property p_wake;
        @(posedge ref_clk) disable iff (rst)
        (s_q.st == MPC_PSM && !pins.wake_n && !off_rel && !rst_rel) |=> !stat.psm && stat.powered;
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not leave power saving");

    ////////////////////////////////////////////////////////////////
    // bounds on how long the detach and system reset phases last, hold checks for the other phases
    localparam int DET_SPAN = DETACH_CYC;
    localparam int RES_HOLD = RESET_CYC - 1;

    property p_off_quiet;
        @(posedge ref_clk) disable iff (rst)
        (s_q.st == MPC_OFF && !on_rel) |=> !stat.powered;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("powered without a long enough on pulse");

    property p_on_steady;
        @(posedge ref_clk) disable iff (rst)
        (s_q.st == MPC_ON && !off_rel && !rst_rel) |=> stat.powered && !stat.detach_req && !stat.sys_reset;
    endproperty
    a_on_steady: assert property (p_on_steady) else $error("left power on without an off pulse");

    sequence s_detach_rise;
        $rose(stat.detach_req);
    endsequence
    property p_detach_bound;
        @(posedge ref_clk) disable iff (rst)
        s_detach_rise |-> ##[1:DET_SPAN] !stat.detach_req;
    endproperty
    a_detach_bound: assert property (p_detach_bound) else $error("detach request never ended");

    property p_detach_ack;
        @(posedge ref_clk) disable iff (rst)
        (stat.detach_req && detach_ack && !rst_rel) |=> !stat.powered && !stat.detach_req;
    endproperty
    a_detach_ack: assert property (p_detach_ack) else $error("no power down after detach done");

    property p_restart_off;
        @(posedge ref_clk) disable iff (rst)
        (s_q.st == MPC_OFF && rst_rel) |=> !stat.sys_reset;
    endproperty
    a_restart_off: assert property (p_restart_off) else $error("restart acted while unpowered");

    sequence s_reset_rise;
        $rose(stat.sys_reset);
    endsequence
    sequence s_reset_hold;
        ##[RES_HOLD:RES_HOLD] stat.sys_reset ##1 (!stat.sys_reset && stat.powered);
    endsequence
    property p_reset_span;
        @(posedge ref_clk) disable iff (rst)
        s_reset_rise |-> s_reset_hold;
    endproperty
    a_reset_span: assert property (p_reset_span) else $error("system reset of wrong length");

    property p_psm_stay;
        @(posedge ref_clk) disable iff (rst)
        (s_q.st == MPC_PSM && pins.wake_n && !off_rel && !rst_rel) |=> stat.psm && stat.powered;
    endproperty
    a_psm_stay: assert property (p_psm_stay) else $error("left power saving without wake");
endmodule

// File: testbench/mpc_host_model.sv
`timescale 1ns/100ps
module mpc_host_model import mpc_pkg::*; #(
    parameter int unsigned RECOVER_CYC = 20
) (
    input wire logic ref_clk,
    output mpc_pins_t pins
);
    logic [2:0] pull_q = 3'h0;
    // released lines float up to the device pull-up
    assign pins = mpc_pins_t'(~pull_q);
    task automatic pulse(input int unsigned idx, input int unsigned cyc);
        @(posedge ref_clk);
        #1 pull_q[idx] = 1'b1;
        repeat (cyc) @(posedge ref_clk);
        #1 pull_q[idx] = 1'b0;
    endtask
    // command port left alone while the module restarts
    task automatic recover();
        repeat (RECOVER_CYC) @(posedge ref_clk);
        #1;
    endtask
endmodule

// File: testbench/testbench.sv
`timescale 1ns/100ps
module testbench import mpc_pkg::*;;
    localparam int unsigned ON = 20;
    localparam int unsigned OFF = 50;
    localparam int unsigned RCYC = 30;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psm_enter = 1'b0;
    logic detach_ack = 1'b0;
    mpc_pins_t pins;
    mpc_stat_t stat;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    mpc_host_model host (.ref_clk(ref_clk), .pins(pins));
    mpc_seq #(.ON_CYC(ON), .OFF_CYC(OFF), .RESTART_CYC(RCYC)) dut (.ref_clk(ref_clk), .rst(rst), .pins(pins),
        .psm_enter(psm_enter), .detach_ack(detach_ack), .stat(stat));
    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int unsigned n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: status bit %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_on();
        host.pulse(1, RCYC);
        tick(3);
        chk(stat.sys_reset, 1'b0);
        host.pulse(2, ON - 1);
        tick(3);
        chk(stat.powered, 1'b0);
        host.pulse(2, ON);
        tick(1);
        chk(stat.powered, 1'b0);
        tick(1);
        chk(stat.powered, 1'b1);
        $display("power on test done");
    endtask
    task automatic t_restart();
        host.pulse(1, RCYC - 1);
        tick(3);
        chk(stat.sys_reset, 1'b0);
        host.pulse(1, RCYC);
        tick(3);
        chk(stat.sys_reset, 1'b1);
        tick(RESET_HOLD_CYC - 2);
        chk(stat.sys_reset, 1'b1);
        tick(1);
        chk(stat.sys_reset, 1'b0);
        chk(stat.powered, 1'b1);
        host.recover();
        $display("restart test done");
    endtask
    task automatic t_psm();
        psm_enter = 1'b1;
        tick(1);
        psm_enter = 1'b0;
        chk(stat.psm, 1'b1);
        host.pulse(0, 1);
        chk(stat.psm, 1'b0);
        $display("wake test done");
    endtask
    task automatic t_off();
        host.pulse(2, OFF);
        tick(3);
        chk(stat.detach_req, 1'b1);
        chk(stat.powered, 1'b1);
        detach_ack = 1'b1;
        tick(1);
        detach_ack = 1'b0;
        chk(stat.detach_req, 1'b0);
        chk(stat.powered, 1'b0);
        $display("power off test done");
    endtask
    task automatic t_off_psm();
        host.pulse(2, ON);
        tick(2);
        chk(stat.powered, 1'b1);
        psm_enter = 1'b1;
        tick(1);
        psm_enter = 1'b0;
        chk(stat.psm, 1'b1);
        host.pulse(2, OFF);
        tick(2);
        chk(stat.detach_req, 1'b1);
        tick(DETACH_WAIT_CYC - 1);
        chk(stat.detach_req, 1'b1);
        tick(1);
        chk(stat.detach_req, 1'b0);
        chk(stat.powered, 1'b0);
        $display("power off from power saving test done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        tick(8);
        rst = 1'b0;
        t_on();
        t_restart();
        t_psm();
        t_off();
        t_off_psm();
        complete_run();
    end
endmodule
